// >>> rtl/cc_blend_pkg.sv
// Constants for the colour-calculator blend stage: state word layout,
// encodings and fixed-point formats. No surrounding assumptions.
package cc_blend_pkg;
  // Avalon word offsets (byte addresses) of the state words
  localparam logic [5:0] OFS_WORD3  = 6'h0C;
  localparam logic [5:0] OFS_WORD4  = 6'h10;
  localparam logic [5:0] OFS_WORD5  = 6'h14;
  localparam logic [5:0] OFS_WORD6  = 6'h18;
  localparam logic [5:0] OFS_WORD7  = 6'h1C;
  localparam logic [5:0] OFS_STATUS = 6'h20;
  localparam logic [5:0] OFS_GSBASE = 6'h24;
  localparam logic [5:0] OFS_VPADDR = 6'h28;
  localparam logic [5:0] OFS_PCOUNT = 6'h2C;
  // Word 2 field
  localparam int LOGIC_EN_BIT     = 0;
  // Word 3 fields
  localparam int ATEST_FMT_BIT    = 15;
  localparam int SEP_ALPHA_BIT    = 13;
  localparam int BLEND_EN_BIT     = 12;
  localparam int ATEST_EN_BIT     = 11;
  localparam int ATEST_FN_LSB     = 8;
  // Word 4 field
  localparam int VP_PTR_LSB       = 5;
  // Word 5 fields
  localparam int DITHER_EN_BIT    = 31;
  localparam int ROUND_DIS_BIT    = 30;
  localparam int LOGIC_FN_LSB     = 16;
  localparam int STATS_EN_BIT     = 15;
  localparam int A_FN_LSB         = 12;
  localparam int A_SRC_LSB        = 7;
  localparam int A_DST_LSB        = 2;
  // Word 6 fields
  localparam int C_FN_LSB         = 29;
  localparam int C_SRC_LSB        = 24;
  localparam int C_DST_LSB        = 19;
  localparam int XDITH_LSB        = 17;
  localparam int YDITH_LSB        = 15;
  localparam int CLAMP_RNG_LSB    = 2;
  localparam int PRE_CLAMP_BIT    = 1;
  localparam int POST_CLAMP_BIT   = 0;
  // Reset values of state words
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  // Channel format: signed 1.8 fixed point, 10 bits, one = 0x100
  localparam int CW = 10;
  localparam logic signed [9:0] FX_ONE  = 10'sh100;
  localparam logic signed [9:0] FX_MONE = -10'sh100;
  localparam logic signed [9:0] FX_ZERO = 10'sh000;
  localparam logic [7:0] DITHER_NEUTRAL = 8'h00;

  typedef enum logic [2:0] {
    compare_always_pass, cmp_never, cmp_less, cmp_equal,
    cmp_lequal, cmp_greater, cmp_notequal, cmp_gequal
  } cmp_fn_t;
  typedef enum logic [2:0] {
    blend_op_add, blend_op_sub, blend_op_rsub, blend_op_min, blend_op_max
  } blend_op_t;
  typedef enum logic [4:0] {
    blend_factor_unity          = 5'h01,
    bf_src_color                = 5'h02,
    bf_src_alpha                = 5'h03,
    bf_dst_alpha                = 5'h04,
    bf_dst_color                = 5'h05,
    blend_factor_src_alpha_sat  = 5'h06,
    bf_const_color              = 5'h07,
    bf_const_alpha              = 5'h08,
    bf_zero                     = 5'h11,
    bf_inv_src_color            = 5'h12,
    bf_inv_src_alpha            = 5'h13,
    bf_inv_dst_alpha            = 5'h14,
    bf_inv_dst_color            = 5'h15,
    bf_inv_const_color          = 5'h17,
    bf_inv_const_alpha          = 5'h18
  } blend_factor_t;
  typedef enum logic [1:0] {
    clamp_zero_to_one, clamp_minus_one_to_one, clamp_to_target_format, clamp_rsvd
  } clamp_rng_t;
  localparam logic [3:0] logic_all_zeros = 4'h0;
  localparam logic [3:0] logic_all_ones  = 4'hF;
  localparam logic [3:0] LOGIC_AND       = 4'h8;
  localparam logic [3:0] LOGIC_COPY      = 4'hC;
  localparam logic alpha_ref_normalized_byte = 1'b0;
  localparam logic alpha_ref_float           = 1'b1;
endpackage : cc_blend_pkg

// >>> rtl/cc_blend_stage.sv
// Colour-calculator blend stage: alpha test, blend, logic op, dither,
// clamping and pixel-count gating over four render targets.
// Assumes one clock, synchronous inputs, Avalon-MM master on the state port.
//
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps

module cc_blend_stage
  import cc_blend_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  // Avalon-MM state port
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Pixel input, channels are signed 1.8 fixed point, index 0 is alpha
  input  wire logic        pix_valid,
  input  wire logic [3:0]  pix_rt_valid,
  input  wire logic [39:0] pix_src,
  input  wire logic [39:0] pix_dst,
  input  wire logic [39:0] pix_const,
  input  wire logic [31:0] pix_src_alpha_f,
  input  wire logic [3:0]  pix_rt_alpha_u8,
  input  wire logic [1:0]  pix_x,
  input  wire logic [1:0]  pix_y,
  input  wire logic        rt_is_int,
  input  wire logic        rt_is_signed,
  input  wire logic        depth_pass,
  input  wire logic        logic_en_in,
  // Output write path
  output logic             out_valid,
  output logic [3:0]       out_rt_write,
  output logic [39:0]      out_color,
  output logic             out_ds_write,
  output logic             dst_read_needed,
  output logic [31:0]      vp_addr
);

  logic [31:0] word3_r, word4_r, word5_r, word6_r, word7_r, gsbase_r;
  logic [31:0] pcount_r;
  logic        rd_pend_r;

  function automatic logic signed [9:0] clamp_ch(input logic signed [9:0] v,
                                                 input logic signed [9:0] lo);
    if (v > FX_ONE) clamp_ch = FX_ONE;
    else if (v < lo) clamp_ch = lo;
    else clamp_ch = v;
  endfunction : clamp_ch

  function automatic logic signed [9:0] range_lo(input logic [1:0] rng,
                                                 input logic sgn);
    case (rng)
      clamp_minus_one_to_one: range_lo = FX_MONE;
      clamp_to_target_format: range_lo = sgn ? FX_MONE : FX_ZERO;
      default:                range_lo = FX_ZERO;
    endcase
  endfunction : range_lo

  function automatic logic signed [9:0] factor(input logic [4:0] f,
      input logic signed [9:0] s, input logic signed [9:0] sa,
      input logic signed [9:0] d, input logic signed [9:0] da,
      input logic signed [9:0] c, input logic signed [9:0] ca);
    logic signed [9:0] sat;
    sat = (sa < FX_ONE - da) ? sa : 10'(FX_ONE - da);
    case (f)
      blend_factor_unity:         factor = FX_ONE;
      bf_src_color:               factor = s;
      bf_src_alpha:               factor = sa;
      bf_dst_alpha:               factor = da;
      bf_dst_color:               factor = d;
      blend_factor_src_alpha_sat: factor = sat;
      bf_const_color:             factor = c;
      bf_const_alpha:             factor = ca;
      bf_inv_src_color:           factor = 10'(FX_ONE - s);
      bf_inv_src_alpha:           factor = 10'(FX_ONE - sa);
      bf_inv_dst_alpha:           factor = 10'(FX_ONE - da);
      bf_inv_dst_color:           factor = 10'(FX_ONE - d);
      bf_inv_const_color:         factor = 10'(FX_ONE - c);
      bf_inv_const_alpha:         factor = 10'(FX_ONE - ca);
      default:                    factor = FX_ZERO;
    endcase
  endfunction : factor

  function automatic logic signed [9:0] blend(input logic [2:0] op,
      input logic signed [9:0] s, input logic signed [9:0] fs,
      input logic signed [9:0] d, input logic signed [9:0] fd);
    logic signed [19:0] ps, pd;
    logic signed [11:0] a, b;
    ps = s * fs;
    pd = d * fd;
    a = 12'(ps >>> 8);
    b = 12'(pd >>> 8);
    case (op)
      blend_op_add:  blend = 10'(a + b);
      blend_op_sub:  blend = 10'(a - b);
      blend_op_rsub: blend = 10'(b - a);
      blend_op_min:  blend = (s < d) ? s : d;
      blend_op_max:  blend = (s > d) ? s : d;
      default:       blend = s;
    endcase
  endfunction : blend

  function automatic logic cmp(input logic [2:0] fn, input logic gt,
                               input logic eq);
    case (fn)
      compare_always_pass: cmp = 1'b1;
      cmp_never:           cmp = 1'b0;
      cmp_less:            cmp = !gt && !eq;
      cmp_equal:           cmp = eq;
      cmp_lequal:          cmp = !gt;
      cmp_greater:         cmp = gt;
      cmp_notequal:        cmp = !eq;
      cmp_gequal:          cmp = gt || eq;
      default:             cmp = 1'b1;
    endcase
  endfunction : cmp

  // Avalon slave: writes in one cycle, reads take one wait state
  logic wr_hit;
  assign wr_hit = ce && avs_write;
  assign avs_waitrequest = avs_read && !rd_pend_r;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = be[i] ? n[i*8 +: 8] : o[i*8 +: 8];
  endfunction : merge

  always_ff @(posedge clk) begin
    if (srst) begin
      word3_r  <= WORD_RST;
      word4_r  <= WORD_RST;
      word5_r  <= WORD_RST;
      word6_r  <= WORD_RST;
      word7_r  <= WORD_RST;
      gsbase_r <= WORD_RST;
    end else if (wr_hit) begin
      case (avs_address)
        OFS_WORD3:  word3_r  <= merge(word3_r, avs_writedata, avs_byteenable);
        OFS_WORD4:  word4_r  <= merge(word4_r, avs_writedata, avs_byteenable);
        OFS_WORD5:  word5_r  <= merge(word5_r, avs_writedata, avs_byteenable);
        OFS_WORD6:  word6_r  <= merge(word6_r, avs_writedata, avs_byteenable);
        OFS_WORD7:  word7_r  <= merge(word7_r, avs_writedata, avs_byteenable);
        OFS_GSBASE: gsbase_r <= merge(gsbase_r, avs_writedata, avs_byteenable);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_pend_r    <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else if (ce) begin
      rd_pend_r <= avs_read && !rd_pend_r;
      if (avs_read && !rd_pend_r) begin
        case (avs_address)
          OFS_WORD3:  avs_readdata <= word3_r;
          OFS_WORD4:  avs_readdata <= word4_r;
          OFS_WORD5:  avs_readdata <= word5_r;
          OFS_WORD6:  avs_readdata <= word6_r;
          OFS_WORD7:  avs_readdata <= word7_r;
          OFS_GSBASE: avs_readdata <= gsbase_r;
          OFS_VPADDR: avs_readdata <= vp_addr;
          OFS_PCOUNT: avs_readdata <= pcount_r;
          OFS_STATUS: avs_readdata <= {30'h0, out_ds_write, dst_read_needed};
          default:    avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Field decode
  logic       blend_on, sep_a, atest_on, pre_cl, post_cl, dith_on, round_dis;
  logic [1:0] clrng;
  logic [3:0] lop;
  assign blend_on  = word3_r[BLEND_EN_BIT] && !rt_is_int;
  assign sep_a     = word3_r[SEP_ALPHA_BIT];
  assign atest_on  = word3_r[ATEST_EN_BIT];
  assign pre_cl    = word6_r[PRE_CLAMP_BIT] && !rt_is_int;
  assign post_cl   = word6_r[POST_CLAMP_BIT] && !rt_is_int;
  assign clrng     = word6_r[CLAMP_RNG_LSB +: 2];
  assign dith_on   = word5_r[DITHER_EN_BIT];
  assign round_dis = word5_r[ROUND_DIS_BIT];
  assign lop       = word5_r[LOGIC_FN_LSB +: 4];
  assign vp_addr   = gsbase_r + {word4_r[31:VP_PTR_LSB], 5'h00};
  // Op depends on D iff its truth table differs between D=0 and D=1
  assign dst_read_needed = (logic_en_in && (lop[3] != lop[2] || lop[1] != lop[0]))
                           || blend_on;

  // Alpha test: byte compare or float compare against reference
  logic [3:0] rt_pass;
  logic       f_gt, f_eq;
  logic [31:0] fr;
  assign fr = word7_r;
  always_comb begin
    f_eq = (pix_src_alpha_f == fr);
    if (pix_src_alpha_f[31] != fr[31]) f_gt = !pix_src_alpha_f[31];
    else if (pix_src_alpha_f[31]) f_gt = pix_src_alpha_f[30:0] < fr[30:0];
    else f_gt = pix_src_alpha_f[30:0] > fr[30:0];
  end
  for (genvar t = 0; t < 4; t++) begin : g_rt
    logic [7:0] a8;
    assign a8 = pix_rt_alpha_u8[t] ? 8'hFF : pix_src[7:0];
    always_comb begin
      if (!atest_on) rt_pass[t] = 1'b1;
      else if (word3_r[ATEST_FMT_BIT] == alpha_ref_float)
        rt_pass[t] = cmp(word3_r[ATEST_FN_LSB +: 3], f_gt, f_eq);
      else
        rt_pass[t] = cmp(word3_r[ATEST_FN_LSB +: 3], a8 > word7_r[7:0],
                         a8 == word7_r[7:0]);
    end
  end

  // Colour path per channel
  logic [39:0] col;
  logic [7:0]  dith_val;
  logic [3:0]  dith_idx;
  assign dith_idx = {2'(pix_y + word6_r[YDITH_LSB +: 2]),
                     2'(pix_x + word6_r[XDITH_LSB +: 2])};
  assign dith_val = {4'h0, dith_idx ^ 4'h5};
  always_comb begin
    logic signed [9:0] s, d, c, sa, da, ca, fs, fd, b, lo, tl;
    logic [4:0] fsrc, fdst;
    logic [2:0] op;
    s = '0; d = '0; c = '0; fs = '0; fd = '0; b = '0;
    fsrc = '0; fdst = '0; op = '0;
    lo = range_lo(clrng, rt_is_signed);
    tl = range_lo(clamp_to_target_format, rt_is_signed);
    sa = pre_cl ? clamp_ch(pix_src[9:0], lo) : pix_src[9:0];
    da = pre_cl ? clamp_ch(pix_dst[9:0], lo) : pix_dst[9:0];
    ca = pre_cl ? clamp_ch(pix_const[9:0], lo) : pix_const[9:0];
    col = '0;
    for (int i = 0; i < 4; i++) begin
      s = pix_src[i*CW +: CW];
      d = pix_dst[i*CW +: CW];
      c = pix_const[i*CW +: CW];
      if (pre_cl) begin
        s = clamp_ch(s, lo);
        d = clamp_ch(d, lo);
        c = clamp_ch(c, lo);
      end
      if (i == 0 && sep_a) begin
        op = word5_r[A_FN_LSB +: 3];
        fsrc = word5_r[A_SRC_LSB +: 5];
        fdst = word5_r[A_DST_LSB +: 5];
      end else begin
        op = word6_r[C_FN_LSB +: 3];
        fsrc = word6_r[C_SRC_LSB +: 5];
        fdst = word6_r[C_DST_LSB +: 5];
      end
      // Alpha channel factors pick the alpha component
      fs = factor(fsrc, (i == 0) ? sa : s, sa, (i == 0) ? da : d, da,
                  (i == 0) ? ca : c, ca);
      fd = factor(fdst, (i == 0) ? sa : s, sa, (i == 0) ? da : d, da,
                  (i == 0) ? ca : c, ca);
      b = blend_on ? blend(op, s, fs, d, fd) : s;
      if (blend_on && post_cl) b = clamp_ch(b, lo);
      if (logic_en_in && !blend_on) begin
        for (int k = 0; k < CW; k++)
          b[k] = lop[{s[k], d[k]}];
      end
      // Dither skipped while blending, unless rounding disabled
      if (dith_on && (round_dis || !blend_on))
        b = 10'(b + $signed({2'b00, dith_val}) - 10'sh008);
      col[i*CW +: CW] = clamp_ch(b, tl);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      out_valid    <= 1'b0;
      out_rt_write <= 4'h0;
      out_color    <= '0;
      out_ds_write <= 1'b0;
    end else if (ce) begin
      out_valid    <= pix_valid;
      out_rt_write <= pix_valid ? (pix_rt_valid & rt_pass) : 4'h0;
      out_color    <= col;
      out_ds_write <= pix_valid && |(pix_rt_valid & rt_pass);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) pcount_r <= 32'h0000_0000;
    else if (ce && pix_valid && word5_r[STATS_EN_BIT] && depth_pass
             && |(pix_rt_valid & rt_pass))
      pcount_r <= pcount_r + 32'h0000_0001;
  end

  count_gate_a: assert property (@(posedge clk) disable iff (srst)
    ce && !word5_r[STATS_EN_BIT] |=> $stable(pcount_r))
    else $error("pixel counter moved while statistics disabled");
  rt_drop_a: assert property (@(posedge clk) disable iff (srst)
    ce && pix_valid && atest_on && word3_r[ATEST_FN_LSB +: 3] == cmp_never
    |=> out_rt_write == 4'h0 && !out_ds_write)
    else $error("never-pass alpha test still wrote");
  ds_any_a: assert property (@(posedge clk) disable iff (srst)
    ce |=> out_ds_write == (out_valid && |out_rt_write))
    else $error("depth write disagrees with target passes");
  vp_form_a: assert property (@(posedge clk) disable iff (srst)
    vp_addr[4:0] == gsbase_r[4:0])
    else $error("viewport address lost alignment");
  dst_skip_a: assert property (@(posedge clk) disable iff (srst)
    !blend_on && logic_en_in && (lop == LOGIC_COPY || lop == logic_all_ones)
    |-> !dst_read_needed)
    else $error("destination read for source-only op");
  alpha_always_a: assert property (@(posedge clk) disable iff (srst)
    ce && pix_valid && (!atest_on || word3_r[ATEST_FN_LSB +: 3] == compare_always_pass)
    |=> out_rt_write == $past(pix_rt_valid))
    else $error("always-pass alpha test dropped a write");
  int_noblend_a: assert property (@(posedge clk) disable iff (srst)
    rt_is_int |-> !blend_on && !pre_cl && !post_cl)
    else $error("integer target blended or clamped by enables");
  wait_one_a: assert property (@(posedge clk) disable iff (srst)
    ce && avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read wait state exceeded one cycle");

  // Output path checks: equal channels stay equal, in-range sources pass through, writes need a pixel and a present target, alpha stays in range
  sep_share_a: assert property (@(posedge clk) disable iff (srst)
    ce && pix_valid && blend_on && !sep_a && !logic_en_in && pix_src[9:0] == pix_src[19:10]
    && pix_dst[9:0] == pix_dst[19:10] && pix_const[9:0] == pix_const[19:10]
    |=> out_color[9:0] == out_color[19:10])
    else $error("alpha blended unlike colour without separate alpha");
  dith_alpha_a: assert property (@(posedge clk) disable iff (srst)
    ce && pix_valid && dith_on && !blend_on && !logic_en_in && !pre_cl
    && pix_src[9:0] == pix_src[19:10] |=> out_color[9:0] == out_color[19:10])
    else $error("dither treated alpha unlike colour");
  int_pass_a: assert property (@(posedge clk) disable iff (srst)
    ce && pix_valid && rt_is_int && rt_is_signed && !logic_en_in && !dith_on
    && $signed(pix_src[9:0]) <= FX_ONE && $signed(pix_src[9:0]) >= FX_MONE
    |=> out_color[9:0] == $past(pix_src[9:0]))
    else $error("integer target source altered within range");
  blend_off_a: assert property (@(posedge clk) disable iff (srst)
    ce && pix_valid && !word3_r[BLEND_EN_BIT] && !logic_en_in && !dith_on && !pre_cl
    && rt_is_signed && $signed(pix_src[9:0]) <= FX_ONE && $signed(pix_src[9:0]) >= FX_MONE
    |=> out_color[9:0] == $past(pix_src[9:0]))
    else $error("source changed with blending disabled");
  idle_quiet_a: assert property (@(posedge clk) disable iff (srst)
    ce && !pix_valid |=> out_rt_write == 4'h0 && !out_ds_write)
    else $error("target write without a pixel");
  rt_subset_a: assert property (@(posedge clk) disable iff (srst)
    ce |=> (out_rt_write & ~$past(pix_rt_valid)) == 4'h0)
    else $error("write to an absent render target");
  out_range_a: assert property (@(posedge clk) disable iff (srst)
    $signed(out_color[9:0]) <= FX_ONE && $signed(out_color[9:0]) >= FX_MONE)
    else $error("alpha output beyond target range");
endmodule : cc_blend_stage

// >>> test/dst_buf_model.sv
// Destination colour buffer model feeding the blend stage's destination port.
// Assumes the bench supplies the stored colour and the stage's read request.
`timescale 1ns/10ps
module dst_buf_model (
  // Read request and stored colour
  input  wire logic        rd_req,
  input  wire logic [39:0] stored,
  // Destination data to the stage
  output logic [39:0]      dst
);
  // An unread buffer shows the inverse, so a skipped read never looks valid;
  // reads see the stored colour directly, no write cache needs flushing
  assign dst = rd_req ? stored : ~stored;
endmodule : dst_buf_model

// >>> test/cc_blend_stage_tb.sv
// Self-checking bench for the colour-calculator blend stage.
// Assumes one 25 MHz clock, Avalon-MM state writes and a destination buffer model.
`timescale 1ns/10ps
module cc_blend_stage_tb;
  import cc_blend_pkg::*;
  logic        clk, srst, avs_read, avs_write, avs_waitrequest, pix_valid;
  logic        rt_is_int, rt_is_signed, depth_pass, logic_en_in, drn;
  logic        out_valid, out_ds_write, dst_read_needed;
  logic [1:0]  pix_x, pix_y;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, vp_addr, pix_src_alpha_f;
  logic [3:0]  pix_rt_valid, pix_rt_alpha_u8, out_rt_write;
  logic [39:0] pix_src, pix_dst, dst_val, out_color;
  int          err_count, compares;

  cc_blend_stage dut_u (.clk, .srst, .ce(1'b1), .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .pix_valid,
    .pix_rt_valid, .pix_src, .pix_dst, .pix_const(40'h0), .pix_src_alpha_f,
    .pix_rt_alpha_u8, .pix_x, .pix_y, .rt_is_int, .rt_is_signed, .depth_pass,
    .logic_en_in, .out_valid, .out_rt_write, .out_color, .out_ds_write,
    .dst_read_needed, .vp_addr);
  dst_buf_model buf_u (.rd_req(dst_read_needed), .stored(dst_val), .dst(pix_dst));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Request held until waitrequest is seen low at a falling edge
  task automatic bus_xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    int   n;
    logic ws;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    ws = 1'b1;
    while (ws !== 1'b0 && n < 20) begin
      @(negedge clk);
      ws = avs_waitrequest;
      q = avs_readdata;
      @(posedge clk);
      n++;
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (ws !== 1'b0) begin
      err_count++;
      $display("unexpected bus timeout");
      end_sim();
    end
  endtask : bus_xfer

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus_xfer(1'b0, a, 32'h0, q);
    chk(nm, 40'(e), 40'(q));
  endtask : rd_chk

  // One pixel in, result checked one cycle later, after the falling edge, by the caller
  task automatic pix(input logic [39:0] s, input logic [39:0] d, input logic [3:0] rtv,
                     input logic [3:0] am);
    @(posedge clk);
    pix_valid <= 1'b1;
    pix_src <= s;
    dst_val <= d;
    pix_rt_valid <= rtv;
    pix_rt_alpha_u8 <= am;
    @(negedge clk);
    drn = dst_read_needed;
    @(posedge clk);
    pix_valid <= 1'b0;
    @(negedge clk);
    chk("out_valid", 40'(1), 40'(out_valid));
  endtask : pix

  function automatic logic cmp_ok(input int f, input logic [7:0] a, input logic [7:0] r);
    case (f)
      0: cmp_ok = 1'b1;
      1: cmp_ok = 1'b0;
      2: cmp_ok = a < r;
      3: cmp_ok = a == r;
      4: cmp_ok = a <= r;
      5: cmp_ok = a > r;
      6: cmp_ok = a != r;
      default: cmp_ok = a >= r;
    endcase
  endfunction : cmp_ok

  function automatic logic [9:0] lop(input logic [3:0] op, input logic [9:0] s,
                                     input logic [9:0] d);
    for (int i = 0; i < 10; i++) lop[i] = op[{s[i], d[i]}];
  endfunction : lop

  task automatic t_regs();
    rd_chk("word6", OFS_WORD6, WORD_RST);
    rd_chk("pcount", OFS_PCOUNT, 32'h0);
    rd_chk("unmapped", 6'h3C, 32'h0);
    wr(OFS_GSBASE, 32'h1234_5000);
    wr(OFS_WORD4, 32'hABCD_EF7F);
    rd_chk("vp_reg", OFS_VPADDR, 32'hBE02_3F60);
    chk("vp_addr", 40'(32'hBE02_3F60), 40'(vp_addr));
    $display("test regs done");
  endtask : t_regs

  // Targets 0 and 2 test alpha FFh, target 1 tests 00h, target 3 absent
  task automatic t_alpha();
    logic [3:0] e;
    wr(OFS_WORD7, 32'h0000_0080);
    for (int f = 0; f < 8; f++) begin
      wr(OFS_WORD3, 32'h800 | 32'(f << ATEST_FN_LSB));
      for (int i = 0; i < 3; i++) e[i] = cmp_ok(f, i[0] ? 8'h00 : 8'hFF, 8'h80);
      e[3] = 1'b0;
      pix(40'h0, 40'h0, 4'h7, 4'h5);
      chk("rt_write", 40'(e), 40'(out_rt_write));
      chk("ds_write", 40'(|e), 40'(out_ds_write));
    end
    $display("test alpha done");
  endtask : t_alpha

  task automatic t_logic();
    logic [9:0] x;
    wr(OFS_WORD3, 32'h0);
    logic_en_in <= 1'b1;
    for (int op = 0; op < 16; op++) begin
      wr(OFS_WORD5, 32'(op) << LOGIC_FN_LSB);
      x = lop(4'(op), 10'h0F0, 10'h03C);
      pix({4{10'h0F0}}, {4{10'h03C}}, 4'h1, 4'h0);
      chk("logic_color", {4{x}}, out_color);
      chk("dst_read", 40'(op[0] != op[1] || op[2] != op[3]), 40'(drn));
    end
    $display("test logic done");
  endtask : t_logic

  // Add with unity factors; alpha uses subtract only when separate
  task automatic t_blend();
    logic [9:0] sv[5] = '{10'h040, 10'h040, 10'h3C0, 10'h3C0, 10'h040};
    logic [9:0] ec[5] = '{10'h060, 10'h060, 10'h020, 10'h3E0, 10'h040};
    logic [9:0] ea[5] = '{10'h060, 10'h020, 10'h020, 10'h3E0, 10'h040};
    logic [4:0] sep = 5'b00010;
    logic [4:0] pre = 5'b00100;
    logic [4:0] ity = 5'b10000;
    wr(OFS_WORD5, 32'h0000_1084);
    logic_en_in <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      wr(OFS_WORD6, 32'h0108_0000 | 32'(pre[i]) << PRE_CLAMP_BIT);
      wr(OFS_WORD3, 32'h1000 | 32'(sep[i]) << SEP_ALPHA_BIT);
      rt_is_int <= ity[i];
      pix({4{sv[i]}}, {4{10'h020}}, 4'h1, 4'h0);
      chk("blend_color", {{3{ec[i]}}, ea[i]}, out_color);
    end
    $display("test blend done");
  endtask : t_blend

  task automatic t_stats();
    logic [31:0] q;
    wr(OFS_WORD3, 32'h0);
    rt_is_int <= 1'b0;
    wr(OFS_WORD5, 32'h0000_8000);
    bus_xfer(1'b0, OFS_PCOUNT, 32'h0, q);
    repeat (3) pix(40'h0, 40'h0, 4'h1, 4'h0);
    rd_chk("count_on", OFS_PCOUNT, q + 32'd3);
    wr(OFS_WORD5, 32'h0);
    repeat (2) pix(40'h0, 40'h0, 4'h1, 4'h0);
    rd_chk("count_off", OFS_PCOUNT, q + 32'd3);
    $display("test stats done");
  endtask : t_stats

  // Float reference 0.5 against alpha 1.0 and -1.0
  task automatic t_alpha_f();
    wr(OFS_WORD7, 32'h3F00_0000);
    wr(OFS_WORD3, 32'h0000_8D00);
    pix_src_alpha_f <= 32'h3F80_0000;
    pix(40'h0, 40'h0, 4'h3, 4'h0);
    chk("rt_float_gt", 40'h3, 40'(out_rt_write));
    @(posedge clk);
    pix_src_alpha_f <= 32'hBF80_0000;
    pix(40'h0, 40'h0, 4'h3, 4'h0);
    chk("rt_float_gt", 40'h0, 40'(out_rt_write));
    wr(OFS_WORD3, 32'h0000_8A00);
    pix(40'h0, 40'h0, 4'h3, 4'h0);
    chk("rt_float_lt", 40'h3, 40'(out_rt_write));
    $display("test alpha float done");
  endtask : t_alpha_f

  // Index {y+yoff, x+xoff} = Ch gives table entry 9h, one lsb above neutral
  task automatic t_dither();
    logic [9:0]  e[3]  = '{10'h041, 10'h060, 10'h061};
    logic [31:0] w5[3] = '{32'h8000_0000, 32'h8000_0000, 32'hC000_0000};
    wr(OFS_WORD6, 32'h010E_8000);
    pix_x <= 2'h1;
    pix_y <= 2'h2;
    for (int i = 0; i < 3; i++) begin
      wr(OFS_WORD3, (i == 0) ? 32'h0 : 32'h0000_1000);
      wr(OFS_WORD5, w5[i]);
      pix({4{10'h040}}, {4{10'h020}}, 4'h1, 4'h0);
      chk("dither_color", {4{e[i]}}, out_color);
    end
    rd_chk("status", OFS_STATUS, 32'h1);
    $display("test dither done");
  endtask : t_dither

  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    $display("unexpected run timeout");
    end_sim();
  end

  initial begin
    srst = 1'b1;
    {avs_read, avs_write, pix_valid, rt_is_int, logic_en_in} = '0;
    {rt_is_signed, depth_pass} = 2'b11;
    {pix_x, pix_y, avs_address, pix_rt_valid, pix_rt_alpha_u8} = '0;
    {avs_writedata, pix_src_alpha_f, pix_src, dst_val} = '0;
    err_count = 0;
    compares = 0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_alpha();
    t_alpha_f();
    t_logic();
    t_blend();
    t_stats();
    t_dither();
    end_sim();
  end
endmodule : cc_blend_stage_tb
